// ==== rtl/bcc_bus_ctrl.v ====
// bcc_bus_ctrl - bus cycle control outputs of the external bus.
// assumes requests and select configuration come from ref_clk logic;
// only the muxed data lines arrive from pins and are synchronised.
//
// Function
// R01 - reference clock output runs at exactly half the input clock.
// R02 - it has 50% duty, toggling on every falling input clock edge.
// R03 - data enable is low only while data moves on the bus, else high.
// R04 - direction high means transmit, low means receive.
// R05 - eight generic selects exist, each active only when enabled.
// R06 - an enabled select goes low when the cycle address is in its space.
// R07 - low bus lines carry address bits 0-7, then 8-bit data.
// R08 - address latch strobe is high during the address phase.
// R09 - disabled selects, and all after reset, stay high.
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.vh"

module bcc_bus_ctrl #(
    parameter SEL_NUM = `BCC_SEL_NUM,
    parameter BLK_W   = `BCC_BLK_W
) (
    input  wire                        ref_clk,
    input  wire                        rst,
    // user side request and answer
    input  wire                        cyc_req,
    input  wire                        cyc_write,
    input  wire                        cyc_io,
    input  wire [`BCC_ADDR_W-1:0]      cyc_addr,
    input  wire [`BCC_DATA_W-1:0]      cyc_wdata,
    output reg                         cyc_ready,
    output reg                         cyc_done,
    output reg  [`BCC_DATA_W-1:0]      cyc_rdata,
    // select configuration
    input  wire [SEL_NUM-1:0]          sel_enable,
    input  wire [SEL_NUM-1:0]          sel_io_space,
    input  wire [SEL_NUM*BLK_W-1:0]    sel_base,
    input  wire [SEL_NUM*BLK_W-1:0]    sel_mask,
    // pins
    output reg                         ref_clk_half,
    output reg  [`BCC_DATA_W-1:0]      muxed_bus_out,
    output reg                         muxed_bus_oe,
    input  wire [`BCC_DATA_W-1:0]      muxed_bus_in,
    output reg  [`BCC_HI_ADDR_W-1:0]   high_addr,
    output reg                         addr_latch,
    output reg                         data_enable_low,
    output reg                         buffer_direction,
    output reg                         generic_select_0_low,
    output reg                         generic_select_1_low,
    output reg                         generic_select_2_low,
    output reg                         generic_select_3_low,
    output reg                         generic_select_4_low,
    output reg                         generic_select_5_low,
    output reg                         generic_select_6_low,
    output reg                         generic_select_7_low
);

    // ------------------------------------------------------------------
    // internal state
    // ------------------------------------------------------------------
    reg  [2:0]              state_r;
    reg                     tick_r;
    reg                     write_r;
    reg  [`BCC_DATA_W-1:0]  wdata_r;
    reg  [`BCC_DATA_W-1:0]  bus_sync1_r;
    reg  [`BCC_DATA_W-1:0]  bus_sync2_r;
    reg  [SEL_NUM-1:0]      sel_low_r;
    reg  [SEL_NUM-1:0]      sel_low_nxt;
    wire [SEL_NUM-1:0]      sel_hit;

    // ------------------------------------------------------------------
    // reference clock output
    // ------------------------------------------------------------------
    // falling edge flop on the one clock: half rate, equal halves
    always @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_clk_half <= `BCC_RST_CLK_HALF;
        end else begin
            ref_clk_half <= ~ref_clk_half; // [R01] [R02]
        end
    end

    // rising edge enable, one pulse per output clock period
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= ~tick_r;
        end
    end

    // ------------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------------
    // read data sees the pins only through the second stage
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_sync1_r <= {`BCC_DATA_W{1'b0}};
            bus_sync2_r <= {`BCC_DATA_W{1'b0}};
        end else begin
            bus_sync1_r <= muxed_bus_in;
            bus_sync2_r <= bus_sync1_r;
        end
    end

    // ------------------------------------------------------------------
    // chip select decode
    // ------------------------------------------------------------------
    bcc_sel_match #(
        .SEL_NUM      (SEL_NUM),
        .ADDR_W       (`BCC_ADDR_W),
        .BLK_W        (BLK_W)
    ) u_match (
        .addr         (cyc_addr),
        .is_io        (cyc_io),
        .sel_enable   (sel_enable),
        .sel_io_space (sel_io_space),
        .sel_base     (sel_base),
        .sel_mask     (sel_mask),
        .hit          (sel_hit)
    );

    // selects change only at the start and end of a cycle
    always @* begin
        sel_low_nxt = sel_low_r;
        if (tick_r) begin
            if ((state_r == `BCC_ST_IDLE) && cyc_req) begin
                sel_low_nxt = ~sel_hit; // [R06]
            end else if (state_r == `BCC_ST_T4) begin
                sel_low_nxt = {SEL_NUM{1'b1}}; // [R09]
            end
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_low_r <= `BCC_RST_SEL_LOW; // [R09]
        end else begin
            sel_low_r <= sel_low_nxt;
        end
    end

    // the select pins are flops of their own, copied from the vector
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            generic_select_0_low <= 1'b1;
            generic_select_1_low <= 1'b1;
            generic_select_2_low <= 1'b1;
            generic_select_3_low <= 1'b1;
            generic_select_4_low <= 1'b1;
            generic_select_5_low <= 1'b1;
            generic_select_6_low <= 1'b1;
            generic_select_7_low <= 1'b1;
        end else begin
            generic_select_0_low <= sel_low_nxt[0]; // [R05]
            generic_select_1_low <= sel_low_nxt[1];
            generic_select_2_low <= sel_low_nxt[2];
            generic_select_3_low <= sel_low_nxt[3];
            generic_select_4_low <= sel_low_nxt[4];
            generic_select_5_low <= sel_low_nxt[5];
            generic_select_6_low <= sel_low_nxt[6];
            generic_select_7_low <= sel_low_nxt[7];
        end
    end

    // ------------------------------------------------------------------
    // bus cycle sequencer: T1 address, T2-T3 data, T4 recovery
    // ------------------------------------------------------------------
    // T1 to T4 each last two input clocks and idle a multiple of two, so pin timing stays symmetric
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r          <= `BCC_ST_IDLE;
            write_r          <= 1'b0;
            wdata_r          <= {`BCC_DATA_W{1'b0}};
            cyc_ready        <= 1'b1;
            cyc_done         <= 1'b0;
            cyc_rdata        <= {`BCC_DATA_W{1'b0}};
            muxed_bus_out    <= {`BCC_DATA_W{1'b0}};
            muxed_bus_oe     <= 1'b0;
            high_addr        <= {`BCC_HI_ADDR_W{1'b0}};
            addr_latch       <= 1'b0;
            data_enable_low  <= 1'b1;
            buffer_direction <= `BCC_RST_DIR;
        end else begin
            cyc_done <= 1'b0;
            if (tick_r) begin
                case (state_r)
                `BCC_ST_IDLE: begin
                    if (cyc_req) begin
                        state_r          <= `BCC_ST_T1;
                        cyc_ready        <= 1'b0;
                        write_r          <= cyc_write;
                        wdata_r          <= cyc_wdata;
                        high_addr        <= cyc_addr[`BCC_ADDR_W-1:
                                                     `BCC_DATA_W];
                        muxed_bus_out    <= cyc_addr[`BCC_DATA_W-1:0]; // [R07]
                        muxed_bus_oe     <= 1'b1;
                        addr_latch       <= 1'b1; // [R08]
                        buffer_direction <= cyc_write; // [R04]
                    end
                end
                `BCC_ST_T1: begin
                    state_r         <= `BCC_ST_T2;
                    addr_latch      <= 1'b0;
                    data_enable_low <= 1'b0; // [R03]
                    // reads release the lines for the far party
                    muxed_bus_out   <= write_r ? wdata_r
                                               : {`BCC_DATA_W{1'b0}}; // [R07]
                    muxed_bus_oe    <= write_r;
                end
                `BCC_ST_T2: begin
                    state_r <= `BCC_ST_T3;
                end
                `BCC_ST_T3: begin
                    state_r         <= `BCC_ST_T4;
                    data_enable_low <= 1'b1; // [R03]
                    muxed_bus_oe    <= 1'b0;
                    if (!write_r) begin
                        // synchroniser lag: the byte read is the pin value sampled at the end of T2
                        cyc_rdata <= bus_sync2_r;
                    end
                end
                `BCC_ST_T4: begin
                    state_r   <= `BCC_ST_IDLE;
                    cyc_ready <= 1'b1;
                    cyc_done  <= 1'b1;
                end
                default: begin
                    state_r         <= `BCC_ST_IDLE;
                    cyc_ready       <= 1'b1;
                    addr_latch      <= 1'b0;
                    data_enable_low <= 1'b1;
                    muxed_bus_oe    <= 1'b0;
                end
                endcase
            end
        end
    end

endmodule // bcc_bus_ctrl

`default_nettype wire

// ==== rtl/bcc_consts.vh ====
// bcc_consts.vh - shared constants of the bus cycle control outputs.
// assumes it is included by bare name from every bcc source file.
`ifndef BCC_CONSTS_VH
`define BCC_CONSTS_VH

// ----------------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------------
`define BCC_ADDR_W       20
`define BCC_DATA_W       8
`define BCC_HI_ADDR_W    12
`define BCC_SEL_NUM      8
`define BCC_BLK_W        10

// ----------------------------------------------------------------------
// field positions of the block number compared by the selects
// ----------------------------------------------------------------------
`define BCC_MEM_BLK_LSB  10
`define BCC_IO_BLK_LSB   6

// ----------------------------------------------------------------------
// bus cycle states, T1 to T4 each one reference clock output period long, idle until a request
// ----------------------------------------------------------------------
`define BCC_ST_IDLE      3'h0
`define BCC_ST_T1        3'h1
`define BCC_ST_T2        3'h2
`define BCC_ST_T3        3'h3
`define BCC_ST_T4        3'h4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BCC_RST_CLK_HALF 1'h0
`define BCC_RST_DIR      1'h1
`define BCC_RST_SEL_LOW  8'hFF

`endif

// ==== rtl/bcc_sel_match.v ====
// bcc_sel_match - address decode for the eight generic chip selects.
// assumes config inputs are static or change only on the ref_clk domain;
// output is combinational and is registered by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.vh"

module bcc_sel_match #(
    parameter SEL_NUM = `BCC_SEL_NUM,
    parameter ADDR_W  = `BCC_ADDR_W,
    parameter BLK_W   = `BCC_BLK_W
) (
    input  wire [ADDR_W-1:0]        addr,
    input  wire                     is_io,
    input  wire [SEL_NUM-1:0]       sel_enable,
    input  wire [SEL_NUM-1:0]       sel_io_space,
    input  wire [SEL_NUM*BLK_W-1:0] sel_base,
    input  wire [SEL_NUM*BLK_W-1:0] sel_mask,
    output reg  [SEL_NUM-1:0]       hit
);

    // ------------------------------------------------------------------
    // block number of a cycle: memory uses the top bits, i/o the port bits
    // ------------------------------------------------------------------
    function [BLK_W-1:0] blk_of;
        input [ADDR_W-1:0] a;
        input              io;
        begin
            if (io) begin
                blk_of = a[`BCC_IO_BLK_LSB +: BLK_W];
            end else begin
                blk_of = a[`BCC_MEM_BLK_LSB +: BLK_W];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // per-select compare; a cleared mask bit is a don't-care bit
    // ------------------------------------------------------------------
    integer i;
    always @* begin
        hit = {SEL_NUM{1'b0}};
        for (i = 0; i < SEL_NUM; i = i + 1) begin
            // disabled selects never hit, so they stay high [R05] [R09]
            hit[i] = sel_enable[i] && (sel_io_space[i] == is_io) &&
                     (((blk_of(addr, is_io) ^ sel_base[i*BLK_W +: BLK_W])
                       & sel_mask[i*BLK_W +: BLK_W]) == {BLK_W{1'b0}});
        end
    end

endmodule // bcc_sel_match

`default_nettype wire

// ==== verif/bcc_bus_partner.sv ====
// bcc_bus_partner - byte memory on the far side of the muxed bus.
// assumes address latched on the strobe; drives lines only on reads.
`timescale 1ns/1ps
`default_nettype none
module bcc_bus_partner (
    input wire logic        ref_clk,
    input wire logic        addr_latch,
    input wire logic        data_enable_low,
    input wire logic        buffer_direction,
    input wire logic        muxed_bus_oe,
    input wire logic [7:0]  muxed_bus_out,
    input wire logic [11:0] high_addr,
    output var logic [7:0]  muxed_bus_in,
    output var logic [19:0] wr_addr,
    output var logic [7:0]  wr_data
);
    logic [19:0] addr_r;
    logic [7:0]  mem [0:255];
    initial muxed_bus_in = 8'h00;
    // released lines toggle so a stale byte can never pass for data
    always @(posedge ref_clk) begin
        if (addr_latch) addr_r <= {high_addr, muxed_bus_out};
        if (!data_enable_low && buffer_direction && muxed_bus_oe) begin
            mem[addr_r[7:0]] <= muxed_bus_out;
            wr_addr <= addr_r;
            wr_data <= muxed_bus_out;
        end
        if (!data_enable_low && !buffer_direction)
            muxed_bus_in <= mem[addr_r[7:0]];
        else
            muxed_bus_in <= ~muxed_bus_in;
    end
endmodule // bcc_bus_partner
`default_nettype wire

// ==== verif/bcc_bus_properties.sv ====
// bcc_bus_properties - timing checks on the bus control pins.
// assumes it is bound into bcc_bus_ctrl; all on the ref_clk rise.
`timescale 1ns/1ps
`default_nettype none
module bcc_bus_properties (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        cyc_write,
    input wire logic [19:0] cyc_addr,
    input wire logic        cyc_ready,
    input wire logic        cyc_done,
    input wire logic [7:0]  sel_enable,
    input wire logic        ref_clk_half,
    input wire logic [7:0]  muxed_bus_out,
    input wire logic        muxed_bus_oe,
    input wire logic [11:0] high_addr,
    input wire logic        addr_latch,
    input wire logic        data_enable_low,
    input wire logic        buffer_direction,
    input wire logic        generic_select_0_low,
    input wire logic        generic_select_1_low,
    input wire logic        generic_select_2_low,
    input wire logic        generic_select_3_low,
    input wire logic        generic_select_4_low,
    input wire logic        generic_select_5_low,
    input wire logic        generic_select_6_low,
    input wire logic        generic_select_7_low
);
    wire [7:0] sel_low = {generic_select_7_low, generic_select_6_low,
        generic_select_5_low, generic_select_4_low, generic_select_3_low,
        generic_select_2_low, generic_select_1_low, generic_select_0_low};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // cycle phases
    // ------------------------------------------------------------
    sequence addr_phase; addr_latch ##1 !addr_latch; endsequence
    sequence data_phase; !data_enable_low [*4] ##1 data_enable_low; endsequence
    // first edge after reset still sees the reset value in $past
    clk_toggle_a: assert property (!$past(rst) |->
        ref_clk_half != $past(ref_clk_half)) else $error("half clock stuck");
    done_time_a: assert property ($fell(cyc_ready) |->
        ##8 cyc_done ##1 !cyc_done) else $error("done not 8 after take");
    latch_phase_a: assert property ($rose(addr_latch) |-> ##1 addr_phase)
        else $error("latch strobe not two clocks");
    den_width_a: assert property ($fell(data_enable_low) |-> data_phase)
        else $error("data enable width wrong");
    den_busy_a: assert property (!data_enable_low |-> !cyc_ready
        && !addr_latch) else $error("data enable outside data phase");
    addr_drive_a: assert property ($rose(addr_latch) |-> muxed_bus_oe &&
        {high_addr, muxed_bus_out} == $past(cyc_addr))
        else $error("address not driven in address phase");
    dir_set_a: assert property ($rose(addr_latch) |->
        buffer_direction == $past(cyc_write)) else $error("direction wrong");
    bus_turn_a: assert property (!data_enable_low |->
        muxed_bus_oe == buffer_direction) else $error("bus drive vs direction");
    idle_sel_a: assert property (cyc_ready |-> sel_low == 8'hFF)
        else $error("select low while idle");
    dis_sel_a: assert property ((~sel_low & ~$past(sel_enable)) == 8'h00)
        else $error("disabled select went low");
endmodule // bcc_bus_properties
bind bcc_bus_ctrl bcc_bus_properties i_props (.*);
`default_nettype wire

// ==== verif/testbench.sv ====
// testbench - directed scenarios for bcc_bus_ctrl.
// assumes the partner memory and the bound checker sit beside it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk, rst, cyc_req, cyc_write, cyc_io;
    logic [19:0] cyc_addr;
    logic [7:0]  cyc_wdata, sel_enable, sel_io_space, sel_seen;
    logic        hv;
    logic [79:0] sel_base, sel_mask;
    wire         cyc_ready, cyc_done, ref_clk_half, muxed_bus_oe;
    wire         addr_latch, data_enable_low, buffer_direction;
    wire [7:0]   cyc_rdata, muxed_bus_out, muxed_bus_in, wr_data, sel_low;
    wire [11:0]  high_addr;
    wire [19:0]  wr_addr;
    int          errors = 0, n_compared = 0, i;
    bcc_bus_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .cyc_req(cyc_req),
        .cyc_write(cyc_write), .cyc_io(cyc_io), .cyc_addr(cyc_addr),
        .cyc_wdata(cyc_wdata), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
        .cyc_rdata(cyc_rdata), .sel_enable(sel_enable),
        .sel_io_space(sel_io_space), .sel_base(sel_base),
        .sel_mask(sel_mask), .ref_clk_half(ref_clk_half),
        .muxed_bus_out(muxed_bus_out), .muxed_bus_oe(muxed_bus_oe),
        .muxed_bus_in(muxed_bus_in), .high_addr(high_addr),
        .addr_latch(addr_latch), .data_enable_low(data_enable_low),
        .buffer_direction(buffer_direction),
        .generic_select_0_low(sel_low[0]), .generic_select_1_low(sel_low[1]),
        .generic_select_2_low(sel_low[2]), .generic_select_3_low(sel_low[3]),
        .generic_select_4_low(sel_low[4]), .generic_select_5_low(sel_low[5]),
        .generic_select_6_low(sel_low[6]), .generic_select_7_low(sel_low[7]));
    bcc_bus_partner i_far (.ref_clk(ref_clk), .addr_latch(addr_latch),
        .data_enable_low(data_enable_low), .buffer_direction(buffer_direction),
        .muxed_bus_oe(muxed_bus_oe), .muxed_bus_out(muxed_bus_out),
        .high_addr(high_addr), .muxed_bus_in(muxed_bus_in),
        .wr_addr(wr_addr), .wr_data(wr_data));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [19:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // request held until one clock after ready drops; selects sampled one clock in
    task automatic cycle(input logic w, io, input logic [19:0] a,
                         input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        cyc_req <= 1'b1;
        cyc_write <= w;
        cyc_io <= io;
        cyc_addr <= a;
        cyc_wdata <= d;
        for (k = 0; k < 20 && cyc_ready !== 1'b0; k++) @(posedge ref_clk) #1;
        @(posedge ref_clk) cyc_req <= 1'b0;
        #1 sel_seen = sel_low;
        for (k = 0; k < 20 && cyc_done !== 1'b1; k++) @(posedge ref_clk) #1;
        check("cyc_done", cyc_done, 1'b1);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_clock();
        repeat (6) begin
            @(negedge ref_clk) #1 hv = ref_clk_half;
            @(posedge ref_clk) #1 check("half stable", ref_clk_half, hv);
            @(negedge ref_clk) #1 check("half toggle", ref_clk_half, !hv);
        end
    endtask
    task automatic t_data();
        cycle(1'b1, 1'b0, 20'hA5C3E, 8'h96);
        check("wr_addr", wr_addr, 20'hA5C3E);
        check("wr_data", wr_data, 8'h96);
        check("dir write", buffer_direction, 1'b1);
        cycle(1'b1, 1'b0, 20'h3F1C1, 8'h5A);
        cycle(1'b0, 1'b0, 20'hA5C3E, 8'h00);
        check("rdata a", cyc_rdata, 8'h96);
        check("dir read", buffer_direction, 1'b0);
        cycle(1'b0, 1'b0, 20'h3F1C1, 8'h00);
        check("rdata b", cyc_rdata, 8'h5A);
    endtask
    // each select owns block i; odd ones decode I/O space
    task automatic t_selects();
        for (i = 0; i < 8; i++) begin
            @(posedge ref_clk) sel_enable <= 8'hFF;
            cycle(1'b1, i[0], i[0] ? 20'(i) << 6 : 20'(i) << 10, 8'h11);
            check("sel hit", sel_seen, 8'(~(8'h01 << i)));
            @(posedge ref_clk) sel_enable <= ~(8'h01 << i);
            cycle(1'b1, i[0], i[0] ? 20'(i) << 6 : 20'(i) << 10, 8'h22);
            check("sel off", sel_seen, 8'hFF);
        end
    endtask
    // mask holes and the space bit both take part in the compare
    task automatic t_decode();
        @(posedge ref_clk) begin
            sel_enable <= 8'hFF;
            sel_mask[20 +: 10] <= 10'h3F0;
        end
        cycle(1'b1, 1'b0, 20'h03400, 8'h33);
        check("sel mask", sel_seen, 8'hFB);
        cycle(1'b0, 1'b1, 20'h00000, 8'h00);
        check("sel space", sel_seen, 8'hFF);
        check("rdata c", cyc_rdata, 8'h33);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        errors++;
        conclude();
    end
    initial begin
        {rst, cyc_req, cyc_write, cyc_io} = 4'h8;
        cyc_addr = 20'h00000;
        cyc_wdata = 8'h00;
        sel_enable = 8'h00;
        sel_io_space = 8'hAA;
        sel_mask = {8{10'h3FF}};
        for (i = 0; i < 8; i++) sel_base[i*10 +: 10] = 10'(i);
        repeat (2) @(posedge ref_clk);
        #1 check("reset den", data_enable_low, 1'b1);
        check("reset sel", sel_low, 8'hFF);
        check("reset ale", addr_latch, 1'b0);
        @(posedge ref_clk) rst <= 1'b0;
        t_clock();
        t_data();
        t_selects();
        t_decode();
        conclude();
    end
endmodule // testbench
`default_nettype wire
